/* File: design/pump_group_pkg.sv */
// constants shared by the pump group sequencer and its helpers
package pump_group_pkg;

    // ---------------------------------------------------------------
    // group size and timing
    // ---------------------------------------------------------------
    localparam int NUM_PUMPS = 5;
    localparam int BASE_PUMPS = 4;
    localparam int NUM_INPUTS = 6;
    localparam int IDX_W = 3;
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SOURCE = 8'h04;
    localparam logic [7:0] ADDR_MAXRUN = 8'h08;
    localparam logic [7:0] ADDR_ENSRC = 8'h0c;
    localparam logic [7:0] ADDR_ROLE = 8'h10;
    localparam logic [7:0] ADDR_MARGIN = 8'h14;
    localparam logic [7:0] ADDR_ON_DELAY = 8'h18;
    localparam logic [7:0] ADDR_OFF_DELAY = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    // ---------------------------------------------------------------
    // field positions of the status word
    // ---------------------------------------------------------------
    localparam int ST_RUN_LSB = 0;
    localparam int ST_LEAD_LSB = 5;
    localparam int ST_LEAD_VALID = 8;
    localparam int ST_STD_MODE = 9;
    localparam int ST_ACTIVE = 10;
    localparam int ST_COUNT_LSB = 11;

    // ---------------------------------------------------------------
    // codes and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] SRC_REGULATOR_REF = 8'h9e;
    localparam logic [2:0] PUMP_NEVER_ACTIVE = 3'h0;
    localparam logic [2:0] PUMP_ALWAYS_ACTIVE = 3'h7;
    localparam logic [6:0] FULL_SCALE = 7'h64;
    localparam logic [6:0] ZERO_SCALE = 7'h00;
    localparam logic [2:0] MAXRUN_RST = 3'h5;
    localparam logic [14:0] ENSRC_RST = 15'h0000;
    localparam logic [4:0] ROLE_RST = 5'h1f;
    localparam logic [15:0] MARGIN_RST = 16'h0000;
    localparam logic [15:0] DELAY_RST = 16'h000a;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pump_group_pkg

/* File: design/tick_gen.sv */
// periodic one-cycle control tick from a cycle divider
module tick_gen #(
    parameter int unsigned DIV = 100000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // tick
    output logic tick
);
    logic [31:0] cnt_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end
        else if (cnt_reg >= DIV - 1)
        begin
            cnt_reg <= 32'h0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule : tick_gen

/* File: design/ring_search.sv */
// first set bit of a mask in circular order from a start index
module ring_search #(
    parameter int N = 5,
    parameter int IW = 3
) (
    // search request
    input wire logic [N-1:0] mask,
    input wire logic [IW-1:0] start,
    input wire logic backward,
    // result
    output logic found,
    output logic [IW-1:0] idx
);
    always_comb
    begin
        int pos;
        pos = 0;
        found = 1'b0;
        idx = start;
        // walk from the far end so the nearest candidate is written last
        for (int k = N - 1; k >= 0; k--)
        begin
            pos = backward ? (int'(start) + N - k) % N : (int'(start) + k) % N;
            if (mask[pos])
            begin
                found = 1'b1;
                idx = IW'(pos);
            end
        end
    end
endmodule : ring_search

/* File: design/pump_group_sequencer.sv */
// pump group sequencer with AXI4-Lite configuration and status
// ---------------------------------------------------------------
// Notes on behaviour
// - at most five pumps, fifth needs expansion
// - one output per pump, relays, collector, option
// - device picks leader, switches additional pumps
// - group acts only while enabled
// - regulator reference source selects standard mode
// - direct reference sets pump count and speed
// - regulator output sets count and speed
// - never add beyond configured simultaneous pump count
// - enable code: never, input one-six, always
// - running pump losing enable stops immediately
// - inactive pump never switched on
// - role: converter-or-grid or grid-only
// - group state readable as status word
// - add pump after full output, low pressure
// - drop pump after zero output, high pressure
// - add first free pump after leader
// - blocked leader stops every running pump
// ---------------------------------------------------------------
module pump_group_sequencer
    import pump_group_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES,
    parameter bit EXPANSION_PRESENT = 1'b1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // axi4-lite write address and data
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // operator enable pins
    input wire logic [NUM_INPUTS-1:0] ENABLE_INPUTS,
    // process values from the regulator, same clock
    input wire logic [6:0] REGULATOR_OUT,
    input wire logic [15:0] PRESSURE_REF,
    input wire logic [15:0] PRESSURE_MEAS,
    input wire logic [6:0] DIRECT_REF,
    // pump outputs
    output logic PUMP_ONE_RELAY,
    output logic PUMP_TWO_RELAY,
    output logic PUMP_THREE_RELAY,
    output logic PUMP_FOUR_OPEN_COLLECTOR_OUT,
    output logic PUMP_FIVE_OPTION_OUT,
    output logic [6:0] LEAD_SPEED
);
    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    logic group_en_reg;
    logic [7:0] source_reg;
    logic [2:0] max_run_reg;
    logic [14:0] en_src_reg;
    logic [4:0] role_reg;
    logic [15:0] margin_reg;
    logic [15:0] on_delay_reg;
    logic [15:0] off_delay_reg;
    logic [NUM_PUMPS-1:0] run_reg;
    logic [IDX_W-1:0] lead_idx_reg;
    logic lead_valid_reg;
    logic [15:0] on_cnt_reg;
    logic [15:0] off_cnt_reg;
    logic [NUM_INPUTS-1:0] din_meta_reg;
    logic [NUM_INPUTS-1:0] din_reg;
    logic tick;
    logic [31:0] status;

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                res[b*8 +: 8] = nw[b*8 +: 8];
        end
        return res;
    endfunction : apply_strb

    function automatic logic [IDX_W-1:0] step_idx(input logic [IDX_W-1:0] i, input logic back);
        if (back)
            return (i == '0) ? IDX_W'(NUM_PUMPS - 1) : i - IDX_W'(1);
        return (i == IDX_W'(NUM_PUMPS - 1)) ? '0 : i + IDX_W'(1);
    endfunction : step_idx

    function automatic logic pump_enabled(input logic [2:0] code,
                                          input logic [NUM_INPUTS-1:0] din);
        if (code == PUMP_NEVER_ACTIVE)
            return 1'b0;
        if (code == PUMP_ALWAYS_ACTIVE)
            return 1'b1;
        return din[code - 3'h1];
    endfunction : pump_enabled

    // ---------------------------------------------------------------
    // axi4-lite slave
    // ---------------------------------------------------------------
    logic wr_go;
    logic rd_go;
    logic wr_hit;
    assign wr_go = AWREADY && AWVALID && WVALID;
    assign rd_go = ARREADY && ARVALID;
    assign wr_hit = AWADDR <= ADDR_STATUS && AWADDR[1:0] == 2'h0;

    logic [31:0] old_word;
    logic [31:0] wr_word;

    // current contents of the addressed register, merged lane by lane
    always_comb
    begin
        unique case (AWADDR)
            ADDR_CTRL: old_word = {31'h0, group_en_reg};
            ADDR_SOURCE: old_word = {24'h0, source_reg};
            ADDR_MAXRUN: old_word = {29'h0, max_run_reg};
            ADDR_ENSRC: old_word = {17'h0, en_src_reg};
            ADDR_ROLE: old_word = {27'h0, role_reg};
            ADDR_MARGIN: old_word = {16'h0, margin_reg};
            ADDR_ON_DELAY: old_word = {16'h0, on_delay_reg};
            ADDR_OFF_DELAY: old_word = {16'h0, off_delay_reg};
            default: old_word = 32'h0;
        endcase
        wr_word = apply_strb(old_word, WDATA, WSTRB);
    end

    // address and data are taken together, one write at a time
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end
        else
        begin
            AWREADY <= AWVALID && WVALID && !AWREADY && !BVALID;
            WREADY <= AWVALID && WVALID && !AWREADY && !BVALID;
            if (wr_go)
            begin
                BVALID <= 1'b1;
                BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (BREADY)
                BVALID <= 1'b0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            group_en_reg <= 1'b0;
            source_reg <= SRC_REGULATOR_REF;
            max_run_reg <= MAXRUN_RST;
            en_src_reg <= ENSRC_RST;
            role_reg <= ROLE_RST;
            margin_reg <= MARGIN_RST;
            on_delay_reg <= DELAY_RST;
            off_delay_reg <= DELAY_RST;
        end
        else if (wr_go)
        begin
            unique case (AWADDR)
                ADDR_CTRL: group_en_reg <= wr_word[0];
                ADDR_SOURCE: source_reg <= wr_word[7:0];
                ADDR_MAXRUN: max_run_reg <= wr_word[2:0];
                ADDR_ENSRC: en_src_reg <= wr_word[14:0];
                ADDR_ROLE: role_reg <= wr_word[4:0];
                ADDR_MARGIN: margin_reg <= wr_word[15:0];
                ADDR_ON_DELAY: on_delay_reg <= wr_word[15:0];
                ADDR_OFF_DELAY: off_delay_reg <= wr_word[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= RESP_OKAY;
        end
        else
        begin
            ARREADY <= ARVALID && !ARREADY && !RVALID;
            if (rd_go)
            begin
                RVALID <= 1'b1;
                RRESP <= RESP_OKAY;
                unique case (ARADDR)
                    ADDR_CTRL: RDATA <= {31'h0, group_en_reg};
                    ADDR_SOURCE: RDATA <= {24'h0, source_reg};
                    ADDR_MAXRUN: RDATA <= {29'h0, max_run_reg};
                    ADDR_ENSRC: RDATA <= {17'h0, en_src_reg};
                    ADDR_ROLE: RDATA <= {27'h0, role_reg};
                    ADDR_MARGIN: RDATA <= {16'h0, margin_reg};
                    ADDR_ON_DELAY: RDATA <= {16'h0, on_delay_reg};
                    ADDR_OFF_DELAY: RDATA <= {16'h0, off_delay_reg};
                    ADDR_STATUS: RDATA <= status;
                    default:
                    begin
                        RDATA <= 32'h0;
                        RRESP <= RESP_SLVERR;
                    end
                endcase
            end
            else if (RREADY)
                RVALID <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // input capture and decode
    // ---------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            din_meta_reg <= '0;
            din_reg <= '0;
        end
        else
        begin
            din_meta_reg <= ENABLE_INPUTS;
            din_reg <= din_meta_reg;
        end
    end

    tick_gen #(.DIV(TICK_DIV)) u_tick (.clk(CLK), .rst(RST), .tick(tick));

    logic [NUM_PUMPS-1:0] active;
    logic [NUM_PUMPS-1:0] fitted;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PUMPS; gi++)
        begin : g_pump
            // the fifth output exists only with the expansion module
            assign fitted[gi] = (gi < BASE_PUMPS) || EXPANSION_PRESENT;
            assign active[gi] = fitted[gi] && pump_enabled(en_src_reg[gi*3 +: 3], din_reg);
        end
    endgenerate

    // ---------------------------------------------------------------
    // sequencing decisions
    // ---------------------------------------------------------------
    logic std_mode;
    logic [NUM_PUMPS-1:0] lead_bit;
    logic [NUM_PUMPS-1:0] kept;
    logic [2:0] kept_cnt;
    logic [6:0] dref;
    logic [2:0] target;
    logic press_low;
    logic press_high;
    logic add_req;
    logic del_req;
    logic add_found;
    logic del_found;
    logic lead_found;
    logic [IDX_W-1:0] add_idx;
    logic [IDX_W-1:0] del_idx;
    logic [IDX_W-1:0] lead_cand;

    assign std_mode = source_reg == SRC_REGULATOR_REF;
    assign lead_bit = NUM_PUMPS'(1) << lead_idx_reg;
    assign kept = run_reg & active;
    assign kept_cnt = 3'($countones(kept));
    assign dref = (DIRECT_REF > FULL_SCALE) ? FULL_SCALE : DIRECT_REF;
    assign press_low = {1'b0, PRESSURE_MEAS} + {1'b0, margin_reg} <= {1'b0, PRESSURE_REF};
    assign press_high = {1'b0, PRESSURE_MEAS} >= {1'b0, PRESSURE_REF} + {1'b0, margin_reg};

    always_comb
    begin
        logic [9:0] prod;
        prod = 10'(dref) * 10'(max_run_reg);
        target = 3'(prod / 10'd100);
        if (target == 3'h0)
            target = 3'h1;
    end

    always_comb
    begin
        if (std_mode)
        begin
            add_req = on_cnt_reg >= on_delay_reg;
            del_req = off_cnt_reg >= off_delay_reg;
        end
        else
        begin
            add_req = kept_cnt < target;
            del_req = kept_cnt > target;
        end
    end

    // additions search forward from the leader, removals backward
    ring_search #(.N(NUM_PUMPS), .IW(IDX_W)) u_add (
        .mask(active & ~kept),
        .start(step_idx(lead_idx_reg, 1'b0)),
        .backward(1'b0),
        .found(add_found),
        .idx(add_idx)
    );

    ring_search #(.N(NUM_PUMPS), .IW(IDX_W)) u_del (
        .mask(kept & ~lead_bit),
        .start(step_idx(lead_idx_reg, 1'b1)),
        .backward(1'b1),
        .found(del_found),
        .idx(del_idx)
    );

    ring_search #(.N(NUM_PUMPS), .IW(IDX_W)) u_lead (
        .mask(active & role_reg),
        .start(step_idx(lead_idx_reg, 1'b0)),
        .backward(1'b0),
        .found(lead_found),
        .idx(lead_cand)
    );

    // ---------------------------------------------------------------
    // pump state, updated on the control tick only
    // ---------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            run_reg <= '0;
            lead_idx_reg <= '0;
            lead_valid_reg <= 1'b0;
        end
        else if (tick)
        begin
            if (!group_en_reg)
            begin
                run_reg <= '0;
                lead_valid_reg <= 1'b0;
            end
            else if (lead_valid_reg && !active[lead_idx_reg])
            begin
                run_reg <= '0;
                lead_valid_reg <= 1'b0;
            end
            else if (!lead_valid_reg)
            begin
                // a zero limit keeps every pump off
                run_reg <= (lead_found && max_run_reg != 3'h0) ? NUM_PUMPS'(1) << lead_cand : '0;
                lead_idx_reg <= lead_found ? lead_cand : lead_idx_reg;
                lead_valid_reg <= lead_found && max_run_reg != 3'h0;
            end
            else if (kept_cnt > max_run_reg && del_found)
                run_reg <= kept & ~(NUM_PUMPS'(1) << del_idx);
            else if (add_req && add_found && kept_cnt < max_run_reg)
                run_reg <= kept | (NUM_PUMPS'(1) << add_idx);
            else if (del_req && del_found)
                run_reg <= kept & ~(NUM_PUMPS'(1) << del_idx);
            else
                run_reg <= kept;
        end
    end

    // hold timers restart whenever a condition drops or a step is requested
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            on_cnt_reg <= '0;
            off_cnt_reg <= '0;
        end
        else if (tick)
        begin
            if (REGULATOR_OUT >= FULL_SCALE && press_low && !add_req)
                on_cnt_reg <= on_cnt_reg + 16'h1;
            else
                on_cnt_reg <= '0;
            if (REGULATOR_OUT == ZERO_SCALE && press_high && !del_req)
                off_cnt_reg <= off_cnt_reg + 16'h1;
            else
                off_cnt_reg <= '0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            LEAD_SPEED <= ZERO_SCALE;
        else if (tick)
            LEAD_SPEED <= !group_en_reg ? ZERO_SCALE : std_mode ? REGULATOR_OUT : dref;
    end

    assign PUMP_ONE_RELAY = run_reg[0];
    assign PUMP_TWO_RELAY = run_reg[1];
    assign PUMP_THREE_RELAY = run_reg[2];
    assign PUMP_FOUR_OPEN_COLLECTOR_OUT = run_reg[3];
    assign PUMP_FIVE_OPTION_OUT = run_reg[4];

    assign status = {18'h0, kept_cnt, group_en_reg, std_mode, lead_valid_reg, lead_idx_reg,
                     run_reg};

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    AST_DISABLED_OFF: assert property (@(posedge CLK) disable iff (RST)
        tick && !group_en_reg |=> run_reg == '0 && LEAD_SPEED == ZERO_SCALE)
        else $error("pumps still running while group disabled");
    AST_MAX_COUNT: assert property (@(posedge CLK) disable iff (RST)
        tick && $countones(run_reg & active) <= max_run_reg
        |=> $countones(run_reg) <= $past(max_run_reg))
        else $error("more pumps running than allowed");
    AST_NO_INACTIVE: assert property (@(posedge CLK) disable iff (RST)
        tick |=> (run_reg & ~$past(active)) == '0)
        else $error("inactive pump switched on");
    AST_LOST_ENABLE: assert property (@(posedge CLK) disable iff (RST)
        tick && (run_reg & ~active) != '0 |=> (run_reg & $past(run_reg & ~active)) == '0)
        else $error("deactivated pump kept running");
    AST_LEAD_BLOCKED: assert property (@(posedge CLK) disable iff (RST)
        tick && group_en_reg && lead_valid_reg && !active[lead_idx_reg]
        |=> run_reg == '0 && !lead_valid_reg)
        else $error("blocked leader did not stop the group");
    AST_LEAD_ROLE: assert property (@(posedge CLK) disable iff (RST)
        tick && !lead_valid_reg |=> !lead_valid_reg || role_reg[lead_idx_reg])
        else $error("grid-only pump chosen as leader");
    AST_DIRECT_SPEED: assert property (@(posedge CLK) disable iff (RST)
        tick && group_en_reg && !std_mode |=> LEAD_SPEED == $past(dref))
        else $error("direct speed not taken from reference");
    AST_TICK_ONLY: assert property (@(posedge CLK) disable iff (RST)
        !tick |=> $stable(run_reg) && $stable(LEAD_SPEED))
        else $error("outputs changed between ticks");
    AST_STD_ADD: assert property (@(posedge CLK) disable iff (RST)
        tick && std_mode && group_en_reg && lead_valid_reg && active[lead_idx_reg]
        && on_cnt_reg < on_delay_reg && kept_cnt <= max_run_reg && !(del_req && del_found)
        |=> $countones(run_reg) <= $past(kept_cnt))
        else $error("pump added before on-delay elapsed");

endmodule : pump_group_sequencer

/* File: sim/pump_field_model.sv */
// field side model: operator enable pins and regulator output
module pump_field_model
    import pump_group_pkg::*;
(
    // clock
    input wire logic clk,
    // settings from the bench
    input wire logic [NUM_INPUTS-1:0] pins_set,
    input wire logic [7:0] reg_set,
    // lines towards the block
    output logic [NUM_INPUTS-1:0] pins,
    output logic [6:0] reg_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // operator keeps the regulator limits at 0 and 100
    always_ff @(posedge clk)
    begin
        pins <= pins_set;
        reg_out <= (reg_set > 8'h64) ? FULL_SCALE : reg_set[6:0];
    end
endmodule : pump_field_model

/* File: sim/pump_group_sequencer_tb.sv */
// self-checking bench for the pump group sequencer
module pump_group_sequencer_tb
    import pump_group_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst, awv, wv, bry, arv, rry, aw_r, w_r, bv, ar_r, rv;
    logic [7:0] awa, ara, rs;
    logic [31:0] wd, rdat;
    logic [1:0] br, rr;
    logic [5:0] pins, ein;
    logic [6:0] dref, rout, spd;
    logic [15:0] pref, pmeas;
    logic [4:0] run;
    logic [73:0] ex;
    logic [73:0] q[$];
    int bad_count, n_compared, m, r;

    pump_group_sequencer #(.TICK_DIV(8)) u_dut (.CLK(clk), .RST(rst),
        .AWADDR(awa), .AWVALID(awv), .AWREADY(aw_r), .WDATA(wd), .WSTRB(4'hf),
        .WVALID(wv), .WREADY(w_r), .BRESP(br), .BVALID(bv), .BREADY(bry),
        .ARADDR(ara), .ARVALID(arv), .ARREADY(ar_r), .RDATA(rdat), .RRESP(rr),
        .RVALID(rv), .RREADY(rry), .ENABLE_INPUTS(ein), .REGULATOR_OUT(rout),
        .PRESSURE_REF(pref), .PRESSURE_MEAS(pmeas), .DIRECT_REF(dref),
        .PUMP_ONE_RELAY(run[0]), .PUMP_TWO_RELAY(run[1]), .PUMP_THREE_RELAY(run[2]),
        .PUMP_FOUR_OPEN_COLLECTOR_OUT(run[3]), .PUMP_FIVE_OPTION_OUT(run[4]),
        .LEAD_SPEED(spd));
    pump_field_model u_field (.clk(clk), .pins_set(pins), .reg_set(rs),
        .pins(ein), .reg_out(rout));

    always #5 clk = ~clk;

    // ---------------------------------------------------------------
    // bus tasks and result monitor
    // ---------------------------------------------------------------
    task automatic tk(input int n);
        repeat (n * 8) @(posedge clk);
    endtask : tk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] rsp = RESP_OKAY);
        @(posedge clk);
        q.push_back({8'h0, rsp, 64'h0});
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        fork
            begin
                do @(posedge clk); while (aw_r !== 1'b1);
                awv <= 1'b0;
            end
            begin
                do @(posedge clk); while (w_r !== 1'b1);
                wv <= 1'b0;
            end
        join
        do @(posedge clk); while (bv !== 1'b1);
        bry <= 1'b0;
    endtask : wr

    // expected word, mask of the bits that matter, response, flagged speed
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk,
        input logic [1:0] rsp, input logic [7:0] sp = 8'h0);
        @(posedge clk);
        q.push_back({sp, rsp, mk, e});
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge clk); while (ar_r !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rry <= 1'b0;
    endtask : rd

    always @(posedge clk)
    begin
        if ((rv === 1'b1 && rry === 1'b1) || (bv === 1'b1 && bry === 1'b1))
        begin
            ex = q.pop_front();
            n_compared++;
            if ((rv === 1'b1 ? rr : br) !== ex[65:64] || (rdat & ex[63:32]) !== ex[31:0]
                || (ex[73] && spd !== ex[72:66]))
            begin
                bad_count++;
                $display("[ERR] %0t read %h resp %h/%h speed %h want %h", $time, rdat, rr, br, spd,
                    ex[31:0]);
            end
        end
    end

    task automatic test_done;
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // a hung handshake ends the run here
    initial
    begin
        #400000;
        bad_count++;
        test_done();
    end

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial
    begin
        {awv, wv, bry, arv, rry} = '0;
        {awa, ara, wd, dref} = '0;
        rst = 1'b1;
        pins = '1;
        rs = 8'h32;
        pref = 16'h03e8;
        pmeas = 16'h03e8;
        m = $urandom(32'hcae82a0e);
        m = $urandom_range(100, 1);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_SOURCE, 32'h9e, '1, RESP_OKAY);
        rd(ADDR_MAXRUN, 32'h5, '1, RESP_OKAY);
        rd(ADDR_ROLE, 32'h1f, '1, RESP_OKAY);
        rd(8'h24, 32'h0, '1, RESP_SLVERR);
        wr(8'h24, '1, RESP_SLVERR);
        wr(ADDR_STATUS, '1);
        rd(ADDR_STATUS, 32'h0, 32'h1f, RESP_OKAY);
        wr(ADDR_ENSRC, 32'h7);
        wr(ADDR_CTRL, 32'h1);
        tk(3);
        rd(ADDR_STATUS, 32'h701, 32'h7ff, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0);
        tk(2);
        rd(ADDR_STATUS, 32'h0, 32'h41f, RESP_OKAY, 8'h80);
        wr(ADDR_ROLE, 32'h1e);
        wr(ADDR_ENSRC, 32'h7fff);
        wr(ADDR_SOURCE, 32'h1);
        wr(ADDR_CTRL, 32'h1);
        tk(3);
        rd(ADDR_STATUS, 32'h122, 32'h3ff, RESP_OKAY, 8'h80);
        dref <= 7'h64;
        tk(8);
        rd(ADDR_STATUS, 32'h1f, 32'h1f, RESP_OKAY, 8'he4);
        dref <= 7'h32;
        tk(8);
        rd(ADDR_STATUS, 32'h1000, 32'h3800, RESP_OKAY);
        r = $urandom_range(100, 0);
        wr(ADDR_MAXRUN, 32'h3);
        dref <= 7'(r);
        tk(8);
        rd(ADDR_STATUS, 32'((r * 3 < 100) ? 1 : r * 3 / 100) << 11, 32'h3800, RESP_OKAY,
            {1'b1, 7'(r)});
        wr(ADDR_ROLE, 32'h1f);
        // full demand, so the enabled follower always joins the leader
        dref <= 7'h64;
        for (int k = 1; k < 7; k++)
        begin
            wr(ADDR_ENSRC, 32'h38 | 32'(k << 6));
            pins <= 6'h1 << (k - 1);
            tk(4);
            rd(ADDR_STATUS, 32'h6, 32'h1f, RESP_OKAY);
            pins <= '0;
            tk(4);
            rd(ADDR_STATUS, 32'h2, 32'h1f, RESP_OKAY);
        end
        wr(ADDR_ROLE, 32'h1a);
        wr(ADDR_ENSRC, 32'h1c8);
        pins <= 6'h1;
        tk(5);
        rd(ADDR_STATUS, 32'h6, 32'h1f, RESP_OKAY);
        pins <= '0;
        tk(4);
        rd(ADDR_STATUS, 32'h0, 32'h11f, RESP_OKAY);
        wr(ADDR_ROLE, 32'h1f);
        dref <= '0;
        wr(ADDR_ENSRC, 32'h7fff);
        wr(ADDR_ON_DELAY, 32'h2);
        wr(ADDR_OFF_DELAY, 32'h2);
        wr(ADDR_MARGIN, 32'(m));
        rd(ADDR_MARGIN, 32'(m), 32'hffff, RESP_OKAY);
        wr(ADDR_SOURCE, 32'h9e);
        tk(4);
        rd(ADDR_STATUS, 32'h0e00, 32'h3e00, RESP_OKAY, 8'hb2);
        pmeas <= pref - 16'(m) + 16'h1;
        rs <= 8'h64;
        tk(6);
        rd(ADDR_STATUS, 32'h0800, 32'h3800, RESP_OKAY, 8'he4);
        pmeas <= pref - 16'(m);
        tk(12);
        rd(ADDR_STATUS, 32'h1800, 32'h3800, RESP_OKAY);
        pmeas <= pref + 16'(m);
        rs <= 8'h0;
        tk(12);
        rd(ADDR_STATUS, 32'h0800, 32'h3800, RESP_OKAY, 8'h80);
        test_done();
    end
endmodule : pump_group_sequencer_tb
